// ==== hw/msd_bank_ram.sv ====
`timescale 1ns/1ns
module msd_bank_ram #(
    parameter int BYTES = 128
) (
    input  wire logic                     core_clk,
    input  wire logic                     reset,
    input  wire logic [$clog2(BYTES)-1:0] addr,
    input  wire logic                     wrByte,
    input  wire logic [7:0]               wdata,
    input  wire logic                     wrBit,
    input  wire logic [2:0]               bitPos,
    input  wire logic                     bitVal,
    output logic [7:0]                    rdata
);
    logic [7:0] mem_q [BYTES];

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < BYTES; i++) begin
                mem_q[i] <= 8'h00;
            end
        end else if (wrByte) begin
            mem_q[addr] <= wdata;
        end else if (wrBit) begin
            mem_q[addr][bitPos] <= bitVal;
        end
    end

    assign rdata = mem_q[addr];
endmodule

// ==== hw/msd_decoder.sv ====
`timescale 1ns/1ns
module msd_decoder #(
    parameter int XRAM_SIZE = msd_pkg::XRAM_BYTES
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire msd_pkg::msd_req_t req,
    input  wire msd_pkg::msd_xreq_t xreq,
    input  wire msd_pkg::msd_stk_t stackOp,
    input  wire logic [7:0]        stackData,
    input  wire logic              indexSel,
    input  wire logic [7:0]        sfrRdata,
    input  wire logic [7:0]        progRdata,
    output logic [7:0]             rdata,
    output logic                   rbit,
    output logic                   sfrSel,
    output logic                   sfrWrite,
    output logic [7:0]             sfrAddr,
    output logic [7:0]             sfrWdata,
    output logic                   sfrBitWrite,
    output logic [2:0]             sfrBitPos,
    output logic                   sfrBitVal,
    output logic                   progWrite,
    output logic [15:0]            progAddr,
    output logic [7:0]             progWdata,
    output logic                   accessError,
    output logic [7:0]             stackTopPointer,
    output logic [1:0]             activeBank,
    output logic                   recordOverflow,
    output logic                   recordUnderflow
);
    logic [7:0]  stack_top_pointer_q;
    logic [7:0]  processor_status_word_q;
    logic [7:0]  program_store_control_q;
    logic [7:0]  ramAddr;
    logic        ramUpper;
    logic        ramWrByte;
    logic        ramWrBit;
    logic [2:0]  ramBitPos;
    logic [7:0]  ramWdata;
    logic        ramBitVal;
    logic [7:0]  lowRdata;
    logic [7:0]  highRdata;
    logic [7:0]  ramRdata;
    logic [7:0]  xram_q [XRAM_SIZE];
    logic [7:0]  indexAddr;
    logic [7:0]  indexReg;
    logic [7:0]  directAddr;
    logic [7:0]  bitByteAddr;
    logic        bitToSfr;
    logic        sfrAccess;
    logic        sfrBitOk;
    logic        stackPush;
    logic        stackPop;
    logic [1:0]  pushCount;
    logic [1:0]  popCount;
    logic        xIsProg;
    logic        xInFactory;
    logic        xInProg;
    logic [5:0]  recordLevel;
    logic        sfrLocal;
    logic        sfrReadPend_q;

    // bank base from status word bits 4:3
    assign activeBank = {processor_status_word_q[msd_pkg::BANK_HIGH_BIT],
                         processor_status_word_q[msd_pkg::BANK_LOW_BIT]};
    assign indexAddr  = {3'b000, activeBank, 2'b00, indexSel};

    // bit address decode, 8k+n in ram, else sfr base in upper five bits
    assign bitToSfr    = req.addr[7];
    assign bitByteAddr = bitToSfr ? {req.addr[7:3], 3'b000}
                                  : msd_pkg::BIT_BYTE_BASE
                                    + {4'h0, req.addr[6:3]};

    assign directAddr = (req.mode == msd_pkg::MSD_MODE_BIT) ? bitByteAddr
                                                           : req.addr;
    assign sfrAccess  = req.valid
                      && req.mode != msd_pkg::MSD_MODE_INDIRECT
                      && req.mode != msd_pkg::MSD_MODE_EXT
                      && directAddr > msd_pkg::DIRECT_LAST;
    assign sfrBitOk   = directAddr[2:0] == 3'b000;

    // pointer, status word and store control answer locally
    assign sfrLocal   = directAddr == msd_pkg::SFR_STACK_PTR
                     || directAddr == msd_pkg::SFR_STATUS_WORD
                     || directAddr == msd_pkg::SFR_PROG_CTL;

    assign stackPush = stackOp == msd_pkg::MSD_STK_PUSH
                    || stackOp == msd_pkg::MSD_STK_CALL;
    assign stackPop  = stackOp == msd_pkg::MSD_STK_POP
                    || stackOp == msd_pkg::MSD_STK_RET;

    // ram port steering: stack traffic wins over operand access
    always_comb begin
        ramAddr   = directAddr;
        ramWrByte = 1'b0;
        ramWrBit  = 1'b0;
        ramBitPos = req.addr[2:0];
        ramWdata  = req.wdata;
        ramBitVal = req.bitVal;
        if (stackPush) begin
            ramAddr   = stack_top_pointer_q + 8'h01;
            ramWrByte = 1'b1;
            ramWdata  = stackData;
        end else if (stackPop) begin
            ramAddr = stack_top_pointer_q;
        end else if (req.valid) begin
            if (req.mode == msd_pkg::MSD_MODE_INDIRECT) begin
                ramAddr   = req.addr;
                ramWrByte = req.write;
            end else if (req.mode == msd_pkg::MSD_MODE_BIT) begin
                ramWrBit = req.write && !bitToSfr;
            end else if (req.mode == msd_pkg::MSD_MODE_DIRECT) begin
                ramWrByte = req.write && !sfrAccess;
            end
        end
    end

    assign ramUpper = ramAddr[7];
    assign indexReg = ramRdata;

    msd_bank_ram #(
        .BYTES(msd_pkg::IRAM_BYTES / 2)
    ) u_low_ram (
        .core_clk(core_clk),
        .reset   (reset),
        .addr    (ramAddr[6:0]),
        .wrByte  (ramWrByte && !ramUpper),
        .wdata   (ramWdata),
        .wrBit   (ramWrBit && !ramUpper),
        .bitPos  (ramBitPos),
        .bitVal  (ramBitVal),
        .rdata   (lowRdata)
    );

    msd_bank_ram #(
        .BYTES(msd_pkg::IRAM_BYTES / 2)
    ) u_high_ram (
        .core_clk(core_clk),
        .reset   (reset),
        .addr    (ramAddr[6:0]),
        .wrByte  (ramWrByte && ramUpper),
        .wdata   (ramWdata),
        .wrBit   (ramWrBit && ramUpper),
        .bitPos  (ramBitPos),
        .bitVal  (ramBitVal),
        .rdata   (highRdata)
    );

    assign ramRdata = ramUpper ? highRdata : lowRdata;

    msd_stack_record u_record (
        .core_clk (core_clk),
        .reset    (reset),
        .pushCount(pushCount),
        .popCount (popCount),
        .overflow (recordOverflow),
        .underflow(recordUnderflow),
        .level    (recordLevel)
    );

    always_comb begin
        pushCount = 2'd0;
        popCount  = 2'd0;
        case (stackOp)
            msd_pkg::MSD_STK_PUSH: pushCount = 2'd1;
            msd_pkg::MSD_STK_INC:  pushCount = 2'd1;
            msd_pkg::MSD_STK_CALL: pushCount = 2'd2;
            msd_pkg::MSD_STK_POP:  popCount  = 2'd1;
            msd_pkg::MSD_STK_DEC:  popCount  = 2'd1;
            msd_pkg::MSD_STK_RET:  popCount  = 2'd2;
            default: begin
                pushCount = 2'd0;
                popCount  = 2'd0;
            end
        endcase
    end

    // stack pointer: stack traffic first, then direct writes at 0x81
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stack_top_pointer_q <= msd_pkg::STACK_PTR_RESET;
        end else if (stackPush || stackOp == msd_pkg::MSD_STK_INC) begin
            stack_top_pointer_q <= stack_top_pointer_q + 8'h01;
        end else if (stackPop || stackOp == msd_pkg::MSD_STK_DEC) begin
            stack_top_pointer_q <= stack_top_pointer_q - 8'h01;
        end else if (sfrAccess && req.write
                     && req.mode == msd_pkg::MSD_MODE_DIRECT
                     && directAddr == msd_pkg::SFR_STACK_PTR) begin
            stack_top_pointer_q <= req.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            processor_status_word_q <= msd_pkg::STATUS_RESET;
        end else if (sfrAccess && req.write
                     && directAddr == msd_pkg::SFR_STATUS_WORD) begin
            if (req.mode == msd_pkg::MSD_MODE_BIT) begin
                processor_status_word_q[req.addr[2:0]] <= req.bitVal;
            end else begin
                processor_status_word_q <= req.wdata;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            program_store_control_q <= msd_pkg::PROG_CTL_RESET;
        end else if (sfrAccess && req.write
                     && req.mode == msd_pkg::MSD_MODE_DIRECT
                     && directAddr == msd_pkg::SFR_PROG_CTL) begin
            program_store_control_q <= req.wdata;
        end
    end

    // external move path: program store when enabled, else xram
    assign xIsProg    = program_store_control_q[msd_pkg::PROG_WREN_BIT];
    assign xInProg    = xreq.addr <= msd_pkg::PROG_LAST;
    assign xInFactory = xreq.addr >= msd_pkg::FACTORY_FIRST
                     && xreq.addr <= msd_pkg::FACTORY_LAST;

    always_ff @(posedge core_clk) begin
        if (xreq.valid && xreq.write && !xIsProg
            && xreq.addr < 16'(XRAM_SIZE)) begin
            xram_q[xreq.addr[$clog2(XRAM_SIZE)-1:0]] <= xreq.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            progWrite <= 1'b0;
            progAddr  <= 16'h0000;
            progWdata <= 8'h00;
        end else begin
            progWrite <= xreq.valid && xreq.write && xIsProg
                      && xInProg && !xInFactory;
            progAddr  <= xreq.addr;
            progWdata <= xreq.wdata;
        end
    end

    // peripheral answers the registered strobe, so external sfr
    // read data is taken one cycle after the request, while the strobe is high
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sfrReadPend_q <= 1'b0;
        end else begin
            sfrReadPend_q <= sfrAccess && !req.write
                          && !sfrLocal;
        end
    end

    // sfr port and read mux, all registered
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sfrSel      <= 1'b0;
            sfrWrite    <= 1'b0;
            sfrAddr     <= 8'h00;
            sfrWdata    <= 8'h00;
            sfrBitWrite <= 1'b0;
            sfrBitPos   <= 3'd0;
            sfrBitVal   <= 1'b0;
            accessError <= 1'b0;
        end else begin
            sfrSel      <= sfrAccess;
            sfrWrite    <= sfrAccess && req.write
                        && req.mode == msd_pkg::MSD_MODE_DIRECT;
            sfrAddr     <= directAddr;
            sfrWdata    <= req.wdata;
            sfrBitWrite <= sfrAccess && req.write && sfrBitOk
                        && req.mode == msd_pkg::MSD_MODE_BIT;
            sfrBitPos   <= req.addr[2:0];
            sfrBitVal   <= req.bitVal;
            accessError <= (sfrAccess && !sfrBitOk
                            && req.mode == msd_pkg::MSD_MODE_BIT)
                        || (xreq.valid && xreq.write && xIsProg
                            && (xInFactory || !xInProg));
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            rdata <= 8'h00;
            rbit  <= 1'b0;
        end else if (sfrReadPend_q) begin
            // external sfr data; a read issued now is dropped
            rdata <= sfrRdata;
            rbit  <= sfrRdata[sfrBitPos];
        end else if (xreq.valid && !xreq.write) begin
            rdata <= xIsProg ? progRdata
                   : (xreq.addr < 16'(XRAM_SIZE))
                     ? xram_q[xreq.addr[$clog2(XRAM_SIZE)-1:0]] : 8'h00;
        end else if (sfrAccess && directAddr == msd_pkg::SFR_STACK_PTR) begin
            rdata <= stack_top_pointer_q;
        end else if (sfrAccess
                     && directAddr == msd_pkg::SFR_STATUS_WORD) begin
            rdata <= processor_status_word_q;
            rbit  <= processor_status_word_q[req.addr[2:0]];
        end else if (sfrAccess
                     && directAddr == msd_pkg::SFR_PROG_CTL) begin
            rdata <= program_store_control_q;
        end else if (req.valid && !stackPush
                     && !sfrAccess) begin
            rdata <= ramRdata;
            rbit  <= ramRdata[req.addr[2:0]];
        end else if (stackPop) begin
            rdata <= ramRdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            stackTopPointer <= msd_pkg::STACK_PTR_RESET;
        end else begin
            stackTopPointer <= stack_top_pointer_q;
        end
    end
endmodule

// ==== hw/msd_pkg.sv ====
package msd_pkg;
    localparam int          PROG_BYTES      = 8320;
    localparam logic [15:0] PROG_LAST       = 16'h207F;
    localparam logic [15:0] FACTORY_FIRST   = 16'h1E00;
    localparam logic [15:0] FACTORY_LAST    = 16'h1FFF;
    localparam int          XRAM_BYTES      = 1024;
    localparam int          IRAM_BYTES      = 256;
    localparam logic [7:0]  DIRECT_LAST     = 8'h7F;
    localparam logic [7:0]  BANK_LAST       = 8'h1F;
    localparam logic [7:0]  BIT_BYTE_BASE   = 8'h20;
    localparam logic [7:0]  SFR_STACK_PTR   = 8'h81;
    localparam logic [7:0]  SFR_STATUS_WORD = 8'hD0;
    localparam logic [7:0]  SFR_PROG_CTL    = 8'h8F;
    localparam logic [7:0]  STACK_PTR_RESET = 8'h07;
    localparam logic [7:0]  STATUS_RESET    = 8'h00;
    localparam logic [7:0]  PROG_CTL_RESET  = 8'h00;
    localparam int          PROG_WREN_BIT   = 0;
    localparam int          BANK_LOW_BIT    = 3;
    localparam int          BANK_HIGH_BIT   = 4;
    localparam int          RECORD_BITS     = 32;

    typedef enum logic [1:0] {
        MSD_MODE_DIRECT,
        MSD_MODE_INDIRECT,
        MSD_MODE_BIT,
        MSD_MODE_EXT
    } msd_mode_t;

    typedef enum logic [2:0] {
        MSD_STK_NONE,
        MSD_STK_PUSH,
        MSD_STK_POP,
        MSD_STK_CALL,
        MSD_STK_RET,
        MSD_STK_INC,
        MSD_STK_DEC
    } msd_stk_t;

    typedef struct packed {
        logic      valid;
        logic      write;
        msd_mode_t mode;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic      bitVal;
    } msd_req_t;

    typedef struct packed {
        logic      valid;
        logic      write;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } msd_xreq_t;
endpackage

// ==== hw/msd_stack_record.sv ====
`timescale 1ns/1ns
module msd_stack_record #(
    parameter int DEPTH = msd_pkg::RECORD_BITS
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic [1:0]  pushCount,
    input  wire logic [1:0]  popCount,
    output logic             overflow,
    output logic             underflow,
    output logic [5:0]       level
);
    logic [DEPTH-1:0] record_q;
    logic [6:0]       fill_q;
    logic [6:0]       fillAfterPush;

    assign fillAfterPush = fill_q + {5'd0, pushCount};

    always_ff @(posedge core_clk) begin
        if (reset) begin
            record_q  <= '0;
            fill_q    <= '0;
            overflow  <= 1'b0;
            underflow <= 1'b0;
        end else begin
            overflow  <= 1'b0;
            underflow <= 1'b0;
            if (pushCount != 2'd0) begin
                record_q <= record_q << pushCount;
                if (fillAfterPush > 7'(DEPTH)) begin
                    overflow <= 1'b1;
                    fill_q   <= 7'(DEPTH);
                end else begin
                    fill_q <= fillAfterPush;
                end
            end else if (popCount != 2'd0) begin
                record_q <= record_q >> popCount;
                if (fill_q < {5'd0, popCount}) begin
                    underflow <= 1'b1;
                    fill_q    <= '0;
                end else begin
                    fill_q <= fill_q - {5'd0, popCount};
                end
            end
        end
    end

    assign level = fill_q[5:0];
endmodule

// ==== tb/msd_decoder_asserts.sv ====
`timescale 1ns/1ns
module msd_decoder_asserts (
    input wire logic               core_clk,
    input wire logic               reset,
    input wire msd_pkg::msd_req_t  req,
    input wire msd_pkg::msd_xreq_t xreq,
    input wire msd_pkg::msd_stk_t  stackOp,
    input wire logic               sfrSel,
    input wire logic [7:0]         sfrAddr,
    input wire logic               sfrBitWrite,
    input wire logic [2:0]         sfrBitPos,
    input wire logic               progWrite,
    input wire logic [15:0]        progAddr,
    input wire logic [7:0]         stackTopPointer,
    input wire logic [1:0]         activeBank,
    input wire logic               recordOverflow,
    input wire logic               recordUnderflow
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic       noStk   = stackOp == msd_pkg::MSD_STK_NONE;
    wire logic       idle    = noStk && !req.valid;
    wire logic       isDir   = req.valid &&
        req.mode == msd_pkg::MSD_MODE_DIRECT;
    wire logic [7:0] reqAddr = req.addr;
    wire logic [2:0] reqPos  = req.addr[2:0];
    wire logic [1:0] bankIn  = req.wdata[4:3];
    // pointer, status and store control are kept inside the decoder
    wire logic       inHouse = req.addr inside {msd_pkg::SFR_STACK_PTR,
        msd_pkg::SFR_STATUS_WORD, msd_pkg::SFR_PROG_CTL};
    wire logic       badPrg  = xreq.addr > msd_pkg::PROG_LAST ||
        xreq.addr inside {[msd_pkg::FACTORY_FIRST:msd_pkg::FACTORY_LAST]};
    sequence quiet2;
        idle [*2];
    endsequence
    sequence lonePush;
        quiet2 ##1 (stackOp == msd_pkg::MSD_STK_PUSH && !req.valid)
        ##1 quiet2;
    endsequence
    AST_PUSH_SP: assert property (
        lonePush |-> stackTopPointer == $past(stackTopPointer, 3) + 8'h01)
        else $error("push did not step pointer");
    AST_RESET_SP: assert property (
        $fell(reset) |-> stackTopPointer == msd_pkg::STACK_PTR_RESET)
        else $error("pointer reset value wrong");
    AST_SFR_DIRECT: assert property (
        isDir && req.addr[7] && noStk && !inHouse
        |=> sfrSel && sfrAddr == $past(reqAddr))
        else $error("direct upper access not steered to sfr");
    AST_NO_SFR: assert property (
        req.valid && noStk && (req.mode == msd_pkg::MSD_MODE_INDIRECT
        || (isDir && !req.addr[7])) |=> !sfrSel)
        else $error("ram access reached sfr port");
    AST_BIT_SFR: assert property (
        req.valid && req.write && req.mode == msd_pkg::MSD_MODE_BIT
        && req.addr[7] |=> sfrBitWrite && sfrBitPos == $past(reqPos)
        && sfrAddr == ($past(reqAddr) & 8'hF8))
        else $error("sfr bit write misrouted");
    AST_BIT_ROWS: assert property (
        sfrBitWrite |-> sfrAddr[2:0] == 3'h0)
        else $error("bit write to byte only sfr");
    AST_PROG_REFUSE: assert property (
        xreq.valid && xreq.write && badPrg |=> !progWrite)
        else $error("refused program write went out");
    AST_PROG_RANGE: assert property (
        progWrite |-> progAddr <= msd_pkg::PROG_LAST && !(progAddr inside
        {[msd_pkg::FACTORY_FIRST:msd_pkg::FACTORY_LAST]}))
        else $error("program write address out of range");
    AST_BANK: assert property (
        isDir && req.write && reqAddr == msd_pkg::SFR_STATUS_WORD
        |-> ##2 activeBank == $past(bankIn, 2))
        else $error("bank does not follow status bits");
    AST_OVF_CAUSE: assert property (
        recordOverflow |-> $past(stackOp) inside {msd_pkg::MSD_STK_PUSH,
        msd_pkg::MSD_STK_CALL, msd_pkg::MSD_STK_INC})
        else $error("overflow without a push");
    AST_UNF_CAUSE: assert property (
        recordUnderflow |-> $past(stackOp) inside {msd_pkg::MSD_STK_POP,
        msd_pkg::MSD_STK_RET, msd_pkg::MSD_STK_DEC})
        else $error("underflow without a pop");
endmodule

// ==== tb/msd_decoder_bench.sv ====
`timescale 1ns/1ns
module msd_decoder_bench;
    localparam msd_pkg::msd_mode_t DIR = msd_pkg::MSD_MODE_DIRECT;
    localparam msd_pkg::msd_mode_t IND = msd_pkg::MSD_MODE_INDIRECT;
    localparam msd_pkg::msd_mode_t BIT = msd_pkg::MSD_MODE_BIT;
    localparam logic [7:0]         BITS [3] = '{8'h00, 8'h13, 8'h7F};
    logic               core_clk, reset, indexSel;
    msd_pkg::msd_req_t  req;
    msd_pkg::msd_xreq_t xreq;
    msd_pkg::msd_stk_t  stackOp;
    logic [7:0]         stackData, rdata, sfrRdata, progRdata, sfrAddr;
    logic [7:0]         sfrWdata, progWdata, stackTopPointer;
    logic [7:0]         sfrHits, progHits;
    logic [15:0]        progAddr;
    logic [23:0]        lastSfr, lastProg;
    logic [2:0]         sfrBitPos;
    logic [1:0]         activeBank;
    logic               rbit, sfrSel, sfrWrite, sfrBitWrite, sfrBitVal;
    logic               progWrite, accessError;
    logic               recordOverflow, recordUnderflow;
    int                 err_count = 0, n_tests = 0, cyc = 0;
    logic [7:0]         errHits = '0, ovfHits = '0, unfHits = '0;

    msd_decoder dut_u (.core_clk, .reset, .req, .xreq, .stackOp,
        .stackData, .indexSel, .sfrRdata, .progRdata, .rdata, .rbit,
        .sfrSel, .sfrWrite, .sfrAddr, .sfrWdata, .sfrBitWrite, .sfrBitPos,
        .sfrBitVal, .progWrite, .progAddr, .progWdata, .accessError,
        .stackTopPointer, .activeBank, .recordOverflow, .recordUnderflow);
    msd_periph_model mdl_u (.core_clk, .reset, .sfrSel, .sfrAddr,
        .sfrWdata, .sfrWrite, .sfrBitVal, .sfrBitWrite, .sfrBitPos,
        .progWrite, .progAddr, .progWdata, .sfrRdata, .progRdata,
        .sfrHits, .progHits, .lastSfr, .lastProg);

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (!reset) begin
            errHits += accessError;
            ovfHits += recordOverflow;
            unfHits += recordUnderflow;
        end
        if (cyc == 2000) begin
            err_count++;
            wrap_up();
        end
    end

    task automatic cmp(input string nm, input logic [23:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic acc(input msd_pkg::msd_mode_t m, input logic w,
                       input logic [7:0] a, d, input logic b = 1'b0);
        @(posedge core_clk);
        req <= '{1'b1, w, m, a, d, b};
        @(posedge core_clk);
        req.valid <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic xacc(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        @(posedge core_clk);
        xreq <= '{1'b1, w, a, d};
        @(posedge core_clk);
        xreq.valid <= 1'b0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic stk(input msd_pkg::msd_stk_t op, input logic [7:0] d);
        @(posedge core_clk);
        stackOp <= op;
        stackData <= d;
        @(posedge core_clk);
        stackOp <= msd_pkg::MSD_STK_NONE;
        @(posedge core_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_record();
        stk(msd_pkg::MSD_STK_POP, 8'h00);
        cmp("underflow", 1, unfHits);
        stk(msd_pkg::MSD_STK_INC, 8'h00);
        stk(msd_pkg::MSD_STK_DEC, 8'h00);
        repeat (16) stk(msd_pkg::MSD_STK_CALL, 8'hC0);
        cmp("overflow", 0, ovfHits);
        stk(msd_pkg::MSD_STK_PUSH, 8'h01);
        cmp("overflow", 1, ovfHits);
        repeat (16) stk(msd_pkg::MSD_STK_RET, 8'h00);
        cmp("underflow", 1, unfHits);
        stk(msd_pkg::MSD_STK_DEC, 8'h00);
        cmp("underflow", 2, unfHits);
    endtask
    task automatic chk_banks();
        for (int b = 0; b < 4; b++) begin
            acc(DIR, 1'b1, 8'hD0, 8'(b << 3));
            cmp("activeBank", 24'(b), activeBank);
        end
        acc(DIR, 1'b1, 8'hD0, 8'h00);
    endtask
    task automatic chk_split();
        logic [7:0] h;
        h = sfrHits;
        acc(IND, 1'b1, 8'h90, 8'hA5);
        cmp("sfrHits", h, sfrHits);
        // a direct write above 0x7F reaches the sfr port
        acc(DIR, 1'b1, 8'h90, 8'h5A);
        cmp("lastSfr", 24'h90_5A10, lastSfr & 24'hFF_FF1F);
        acc(DIR, 1'b0, 8'h90, 8'h00);
        cmp("rdata", 8'h6F, rdata);
        acc(IND, 1'b0, 8'h90, 8'h00);
        cmp("rdata", 8'hA5, rdata);
        acc(DIR, 1'b1, 8'h10, 8'h33);
        acc(IND, 1'b0, 8'h10, 8'h00);
        cmp("rdata", 8'h33, rdata);
    endtask
    task automatic chk_bits();
        logic [7:0] a;
        for (int i = 0; i < 3; i++) begin
            a = BITS[i];
            acc(BIT, 1'b1, a, 8'h00, 1'b1);
            acc(DIR, 1'b0, 8'h20 + (a >> 3), 8'h00);
            cmp("rdata", 8'h01 << a[2:0], rdata);
            acc(BIT, 1'b0, a, 8'h00);
            cmp("rbit", 1'b1, rbit);
        end
        acc(BIT, 1'b1, 8'h8B, 8'h00, 1'b1);
        cmp("lastSfr", 24'h88_000B, lastSfr & 24'hFF_FF1F);
        acc(BIT, 1'b0, 8'h8B, 8'h00);
        cmp("rbit", 1'b0, rbit);
    endtask
    task automatic chk_stack();
        acc(DIR, 1'b1, 8'h81, 8'hFE);
        stk(msd_pkg::MSD_STK_PUSH, 8'h11);
        stk(msd_pkg::MSD_STK_PUSH, 8'h22);
        acc(IND, 1'b0, 8'hFF, 8'h00);
        cmp("rdata", 8'h11, rdata);
        acc(DIR, 1'b0, 8'h00, 8'h00);
        cmp("rdata", 8'h22, rdata);
        cmp("stackTopPointer", 8'h00, stackTopPointer);
    endtask
    task automatic chk_prog();
        logic [7:0] p;
        logic [7:0] e;
        p = progHits;
        e = errHits;
        xacc(1'b1, 16'h03FF, 8'h5A);
        xacc(1'b0, 16'h03FF, 8'h00);
        cmp("rdata", 8'h5A, rdata);
        cmp("progHits", p, progHits);
        acc(DIR, 1'b1, 8'h8F, 8'h01);
        xacc(1'b1, 16'h0100, 8'hC3);
        cmp("lastProg", 24'h01_00C3, lastProg);
        xacc(1'b1, 16'h207F, 8'h3C);
        cmp("lastProg", 24'h20_7F3C, lastProg);
        xacc(1'b1, 16'h1E00, 8'h77);
        xacc(1'b1, 16'h2080, 8'h77);
        cmp("progHits", p + 2, progHits);
        cmp("accessError", e + 2, errHits);
        acc(DIR, 1'b1, 8'h8F, 8'h00);
    endtask

    initial begin
        reset = 1'b1;
        req = '0;
        xreq = '0;
        stackOp = msd_pkg::MSD_STK_NONE;
        stackData = 8'h00;
        indexSel = 1'b0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1;
        cmp("stackTopPointer", 8'h07, stackTopPointer);
        cmp("activeBank", 2'h0, activeBank);
        chk_record();
        chk_banks();
        chk_split();
        chk_bits();
        chk_stack();
        chk_prog();
        wrap_up();
    end
endmodule

bind msd_decoder msd_decoder_asserts chk_u (.core_clk, .reset, .req, .xreq,
    .stackOp, .sfrSel, .sfrAddr, .sfrBitWrite, .sfrBitPos, .progWrite,
    .progAddr, .stackTopPointer, .activeBank, .recordOverflow,
    .recordUnderflow);

// ==== tb/msd_periph_model.sv ====
`timescale 1ns/1ns
module msd_periph_model (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        sfrSel,
    input  wire logic [7:0]  sfrAddr,
    input  wire logic [7:0]  sfrWdata,
    input  wire logic        sfrBitWrite,
    input  wire logic [2:0]  sfrBitPos,
    input  wire logic        sfrWrite,
    input  wire logic        sfrBitVal,
    input  wire logic        progWrite,
    input  wire logic [15:0] progAddr,
    input  wire logic [7:0]  progWdata,
    output logic [7:0]       sfrRdata,
    output logic [7:0]       progRdata,
    output logic [7:0]       sfrHits,
    output logic [7:0]       progHits,
    output logic [23:0]      lastSfr,
    output logic [23:0]      lastProg
);
    logic [7:0] noise;
    // unselected sfr read data toggles so stale data never looks valid
    assign sfrRdata  = sfrSel ? ~sfrAddr : noise;
    assign progRdata = progAddr[7:0] ^ 8'h3C;
    always @(posedge core_clk) begin
        noise <= reset ? 8'h55 : ~noise;
        if (reset) begin
            sfrHits  <= 8'h00;
            progHits <= 8'h00;
        end
        if (!reset && (sfrSel || sfrBitWrite)) begin
            sfrHits <= sfrHits + 8'h01;
            lastSfr <= {sfrAddr, sfrWdata, 3'h0, sfrWrite, sfrBitVal,
                        sfrBitPos};
        end
        if (!reset && progWrite) begin
            progHits <= progHits + 8'h01;
            lastProg <= {progAddr, progWdata};
        end
    end
endmodule
